// ---- hdl/iss_pkg.sv ----
package iss_pkg;
  localparam logic [7:0] CTRL1_OFF = 8'h00;
  localparam logic [7:0] DATA_OFF = 8'h04;
  localparam logic [7:0] ADDR_OFF = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
  localparam logic [7:0] WAKE_OFF = 8'h14;
  localparam int BIT_DONE = 7;
  localparam int BIT_HIT = 6;
  localparam int BIT_BUSY = 5;
  localparam int BIT_TXSEL = 4;
  localparam int BIT_ACKCTL = 3;
  localparam int BIT_RW = 2;
  localparam int BIT_WAKE = 1;
  localparam int BIT_RXACK = 0;
  localparam logic [7:0] CTRL1_RESET = 8'h81;
  localparam logic [7:0] CTRL1_WMASK = 8'h1A;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_HIT = 1;
  localparam int IRQ_STOP = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
endpackage

// ---- hdl/iss_sync_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module iss_sync_bank (
  input wire logic clock,
  input wire logic resetN,
  input wire logic [1:0] asyncIn,
  output logic [1:0] syncOut
);
  logic [1:0] meta_q;
  // First stage feeds only the second stage
  genvar i;
  for (i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clock or negedge resetN) begin
      if (!resetN) begin
        meta_q[i] <= 1'b1;
        syncOut[i] <= 1'b1;
      end else begin
        meta_q[i] <= asyncIn[i];
        syncOut[i] <= meta_q[i];
      end
    end
  end
endmodule // iss_sync_bank
`default_nettype wire

// ---- hdl/iss_i2c_slave.sv ----
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Done flag low while a data byte shifts, sets, interrupts
// - Address hit flag on own address
// - Ack control bit driven on ninth clock
// - Read/write bit captured after address match
// - Wake enable lets address match wake
// - Master ack sampled into received-ack flag
// - Transmitter releases SDA after master nack
// - One shared data register both directions
// - Data only through shared data register
// - Compare against bits seven to one
// - Hold SCL low until data write, or data read in receive mode
module iss_i2c_slave
  import iss_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic irq,
  output logic wakeReq
);
  import iss_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_ACK = 4'b0100,
    ST_HOLD = 4'b1000
  } iss_state_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] shData;
    logic [7:0] ownAddr;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    iss_state_t state;
    logic [3:0] bitCnt;
    logic addrPhase;
    logic active;
    logic sclPrev;
    logic sdaPrev;
    logic sdaDrive;
    logic sclHold;
    logic wake;
    logic awGot;
    logic wGot;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } iss_regs_t;

  iss_regs_t cur_q, cur_d;
  logic [1:0] rstSync_q;
  logic resetN;
  logic [1:0] pinSync;
  logic scl, sda, sclRise, sclFall, startCond, stopCond;
  logic doWrite, doRead;

  // Reset stages kept apart from the state so it has a single driver
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign resetN = rstSync_q[1];

  iss_sync_bank u_sync (
    .clock(clock),
    .resetN(resetN),
    .asyncIn({sclIn, sdaIn}),
    .syncOut(pinSync)
  );
  assign scl = pinSync[1];
  assign sda = pinSync[0];
  assign sclRise = scl && !cur_q.sclPrev;
  assign sclFall = !scl && cur_q.sclPrev;
  assign startCond = scl && cur_q.sclPrev && cur_q.sdaPrev && !sda;
  assign stopCond = scl && cur_q.sclPrev && !cur_q.sdaPrev && sda;
  assign doWrite = cur_q.awGot && cur_q.wGot && !cur_q.bValid;
  assign doRead = s_axi_arvalid && s_axi_arready;

  always_comb begin
    cur_d = cur_q;
    cur_d.sclPrev = scl;
    cur_d.sdaPrev = sda;
    cur_d.wake = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      cur_d.awGot = 1'b1;
      cur_d.awAddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      cur_d.wGot = 1'b1;
      cur_d.wData = s_axi_wdata;
      cur_d.wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      cur_d.bValid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      cur_d.rValid = 1'b0;
    end
    // Serial engine
    case (cur_q.state)
      ST_IDLE: begin
        cur_d.sdaDrive = 1'b0;
      end
      ST_SHIFT: begin
        if (sclRise) begin
          cur_d.bitCnt = cur_q.bitCnt + 4'h1;
          if (!(cur_q.ctrl[BIT_TXSEL] && !cur_q.addrPhase)) begin
            cur_d.shData = {cur_q.shData[6:0], sda};
          end
        end
        if (sclFall) begin
          if (cur_q.bitCnt == BITS_PER_BYTE) begin
            cur_d.state = ST_ACK;
            cur_d.sdaDrive = 1'b0;
            if (cur_q.addrPhase) begin
              if (cur_q.shData[7:1] == cur_q.ownAddr[7:1]) begin
                cur_d.ctrl[BIT_HIT] = 1'b1;
                cur_d.ctrl[BIT_RW] = cur_q.shData[0];
                cur_d.sdaDrive = 1'b1;
                cur_d.wake = cur_q.ctrl[BIT_WAKE];
              end else begin
                cur_d.active = 1'b0;
                cur_d.ctrl[BIT_HIT] = 1'b0;
              end
            end else if (!cur_q.ctrl[BIT_TXSEL]) begin
              cur_d.sdaDrive = !cur_q.ctrl[BIT_ACKCTL];
            end
          end else if (cur_q.ctrl[BIT_TXSEL] && !cur_q.addrPhase) begin
            cur_d.sdaDrive = !cur_q.shData[7];
            cur_d.shData = {cur_q.shData[6:0], 1'b0};
          end
        end
      end
      ST_ACK: begin
        if (sclRise && cur_q.active && cur_q.ctrl[BIT_TXSEL]
            && !cur_q.addrPhase) begin
          cur_d.ctrl[BIT_RXACK] = sda;
        end
        if (sclFall) begin
          cur_d.sdaDrive = 1'b0;
          cur_d.bitCnt = 4'h0;
          if (!cur_q.active) begin
            cur_d.state = ST_IDLE;
          end else begin
            cur_d.ctrl[BIT_DONE] = 1'b1;
            cur_d.irqStat[cur_q.addrPhase ? IRQ_HIT : IRQ_DONE] = 1'b1;
            cur_d.sclHold = 1'b1;
            cur_d.state = ST_HOLD;
            // Nack from master: SDA stays released for STOP
            if (cur_q.ctrl[BIT_TXSEL] && !cur_q.addrPhase
                && cur_q.ctrl[BIT_RXACK]) begin
              cur_d.sclHold = 1'b0;
              cur_d.state = ST_IDLE;
            end
          end
          cur_d.addrPhase = 1'b0;
        end
      end
      ST_HOLD: begin
        cur_d.sdaDrive = 1'b0;
      end
      default: begin
        cur_d.state = ST_IDLE;
      end
    endcase
    // Register writes
    if (doWrite) begin
      cur_d.awGot = 1'b0;
      cur_d.wGot = 1'b0;
      cur_d.bValid = 1'b1;
      cur_d.bResp = RESP_OKAY;
      case (cur_q.awAddr)
        CTRL1_OFF: begin
          if (cur_q.wStrb[0]) begin
            cur_d.ctrl = (cur_d.ctrl & ~CTRL1_WMASK)
              | (cur_q.wData[7:0] & CTRL1_WMASK);
          end
        end
        DATA_OFF: begin
          if (cur_q.wStrb[0]) begin
            cur_d.shData = cur_q.wData[7:0];
            if (cur_q.state == ST_HOLD) begin
              cur_d.sclHold = 1'b0;
              cur_d.state = ST_SHIFT;
              cur_d.ctrl[BIT_DONE] = 1'b0;
              if (cur_q.ctrl[BIT_TXSEL]) begin
                cur_d.sdaDrive = !cur_q.wData[7];
                cur_d.shData = {cur_q.wData[6:0], 1'b0};
              end
            end
          end
        end
        ADDR_OFF: begin
          if (cur_q.wStrb[0]) begin
            cur_d.ownAddr = cur_q.wData[7:0];
          end
        end
        IRQ_STAT_OFF: begin
          // Hardware set wins over software clear
          cur_d.irqStat = cur_d.irqStat & ~(cur_q.wData[2:0]
            & ~(cur_d.irqStat & ~cur_q.irqStat));
        end
        IRQ_MASK_OFF: begin
          cur_d.irqMask = cur_q.wData[2:0];
        end
        default: begin
          cur_d.bResp = RESP_SLVERR;
        end
      endcase
    end
    // Register reads
    if (doRead) begin
      cur_d.rValid = 1'b1;
      cur_d.rResp = RESP_OKAY;
      cur_d.rData = 32'h0000_0000;
      case (s_axi_araddr[7:0])
        CTRL1_OFF: cur_d.rData[7:0] = cur_q.ctrl;
        DATA_OFF: begin
          cur_d.rData[7:0] = cur_q.shData;
          if (cur_q.state == ST_HOLD && !cur_q.ctrl[BIT_TXSEL]) begin
            cur_d.sclHold = 1'b0;
            cur_d.state = ST_SHIFT;
            cur_d.ctrl[BIT_DONE] = 1'b0;
          end
        end
        ADDR_OFF: cur_d.rData[7:0] = cur_q.ownAddr;
        IRQ_STAT_OFF: cur_d.rData[2:0] = cur_q.irqStat;
        IRQ_MASK_OFF: cur_d.rData[2:0] = cur_q.irqMask;
        default: cur_d.rResp = RESP_SLVERR;
      endcase
    end
    // Bus conditions override the engine
    if (startCond) begin
      cur_d.ctrl[BIT_BUSY] = 1'b1;
      cur_d.ctrl[BIT_HIT] = 1'b0;
      cur_d.state = ST_SHIFT;
      cur_d.bitCnt = 4'h0;
      cur_d.addrPhase = 1'b1;
      cur_d.active = 1'b1;
      cur_d.sdaDrive = 1'b0;
      cur_d.sclHold = 1'b0;
    end
    if (stopCond) begin
      cur_d.ctrl[BIT_BUSY] = 1'b0;
      cur_d.irqStat[IRQ_STOP] = 1'b1;
      cur_d.state = ST_IDLE;
      cur_d.active = 1'b0;
      cur_d.sdaDrive = 1'b0;
      cur_d.sclHold = 1'b0;
    end
  end

  // Line history resets to the idle level so no false edge follows reset
  always_ff @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      cur_q <= '{ctrl: CTRL1_RESET, state: ST_IDLE, sclPrev: 1'b1,
        sdaPrev: 1'b1, default: '0};
    end else begin
      cur_q <= cur_d;
    end
  end

  assign s_axi_awready = !cur_q.awGot && !cur_q.bValid;
  assign s_axi_wready = !cur_q.wGot && !cur_q.bValid;
  assign s_axi_bvalid = cur_q.bValid;
  assign s_axi_bresp = cur_q.bResp;
  assign s_axi_arready = !cur_q.rValid;
  assign s_axi_rvalid = cur_q.rValid;
  assign s_axi_rdata = cur_q.rData;
  assign s_axi_rresp = cur_q.rResp;
  // Open drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe = cur_q.sdaDrive;
  assign sclOut = 1'b0;
  assign sclOe = cur_q.sclHold;
  assign irq = |(cur_q.irqStat & cur_q.irqMask);
  assign wakeReq = cur_q.wake;
endmodule // iss_i2c_slave
`default_nettype wire

// ---- verif/iss_i2c_slave_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module iss_i2c_slave_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sclIn,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic wakeReq
);
  logic quiet;
  // Release may trail the access by a cycle or two, so demand a quiet run
  assign quiet = sclOe && !s_axi_wvalid && !s_axi_arvalid && !s_axi_rvalid
    && !s_axi_bvalid;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  chk_ack_on_low: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data line pulled while clock high");
  chk_sda_steady: assert property (
    sclIn && $past(sclIn) && $past(sclIn, 2) |-> $stable(sdaOe))
    else $error("data line moved while clock high");
  chk_stretch_low: assert property ($rose(sclOe) |-> !sclIn)
    else $error("stretch began while clock high");
  chk_hold_scl: assert property (quiet [*3] |=> sclOe)
    else $error("clock released without data access");
  chk_wake_pulse: assert property (wakeReq |=> !wakeReq)
    else $error("wake request longer than a cycle");
  chk_wake_ack: assert property (wakeReq |-> ##[0:24] sdaOe)
    else $error("wake without address acknowledge");
endmodule // iss_i2c_slave_chk
bind iss_i2c_slave iss_i2c_slave_chk u_chk (.*);
`default_nettype wire

// ---- verif/iss_i2c_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module iss_i2c_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic sclLow,
  output logic sdaLow
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // No timeout on stretching; the bench watchdog cuts a hang
  task automatic slot(input logic low, output logic seen);
    #65 sdaLow = low;
    #65 sclLow = 1'b0;
    wait (scl);
    #70 seen = sda;
    sclLow = 1'b1;
  endtask
  task automatic start();
    #100 sdaLow = 1'b1;
    #100 sclLow = 1'b1;
  endtask
  task automatic stop();
    #65 sdaLow = 1'b1;
    #65 sclLow = 1'b0;
    wait (scl);
    #70 sdaLow = 1'b0;
    #100;
  endtask
  task automatic wrByte(input logic [7:0] b, output logic nak);
    logic x;
    for (int i = 7; i >= 0; i--) slot(!b[i], x);
    slot(1'b0, nak);
    #200;
  endtask
  task automatic rdByte(output logic [7:0] b, input logic nak);
    logic x;
    for (int i = 7; i >= 0; i--) slot(1'b0, b[i]);
    slot(!nak, x);
    #200;
  endtask
endmodule // iss_i2c_master_model
`default_nettype wire

// ---- verif/iss_i2c_slave_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module iss_i2c_slave_test;
  import iss_pkg::*;
  logic clock, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, sclOe, sdaOe, irq;
  logic wakeReq, mScl, mSda, nak, sclO, sdaO;
  logic [7:0] got, rd;
  wire logic sclW, sdaW;
  int mismatches, checkCount, wakes;
  // Pull-ups: any party pulling low wins
  assign sclW = !(sclOe || mScl);
  assign sdaW = !(sdaOe || mSda);
  iss_i2c_slave DUT (.*, .sclIn(sclW), .sdaIn(sdaW), .sclOut(sclO),
    .sdaOut(sdaO));
  iss_i2c_master_model m (.scl(sclW), .sda(sdaW), .sclLow(mScl),
    .sdaLow(mSda));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = !clock;
  end
  always @(posedge clock) if (wakeReq === 1'b1) wakes++;
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checkCount++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] r = 2'h0);
    @(posedge clock);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clock); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clock); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp({6'h0, s_axi_bresp}, {6'h0, r});
  endtask
  task automatic rr(input logic [7:0] a, input logic [1:0] r = 2'h0);
    @(posedge clock);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata[7:0];
    cmp({6'h0, s_axi_rresp}, {6'h0, r});
  endtask
  task automatic ck(input logic [7:0] a, mask, e);
    rr(a);
    cmp(rd & mask, e);
  endtask
  // Irq is registered; let the last write land first
  task automatic ci(input logic e);
    repeat (2) @(posedge clock);
    cmp({7'h0, irq}, {7'h0, e});
  endtask
  task automatic testRegs();
    ck(CTRL1_OFF, 8'hFF, 8'h81);
    ck(IRQ_MASK_OFF, 8'hFF, 8'h00);
    rr(WAKE_OFF, RESP_SLVERR);
    wr(WAKE_OFF, 8'hFF, RESP_SLVERR);
    wr(CTRL1_OFF, 8'hFF);
    ck(CTRL1_OFF, 8'hFF, 8'h9B);
    wr(CTRL1_OFF, 8'h00);
    ck(CTRL1_OFF, 8'hFF, 8'h81);
    wr(ADDR_OFF, 8'hA9);
    ck(ADDR_OFF, 8'hFF, 8'hA9);
    cmp({6'h0, sclO, sdaO}, 8'h00);
    $display("testRegs done");
  endtask
  task automatic testMiss();
    m.start();
    m.wrByte(8'h22, nak);
    cmp({7'h0, nak}, 8'h01);
    cmp({7'h0, sclOe}, 8'h00);
    ck(CTRL1_OFF, 8'h40, 8'h00);
    m.stop();
    $display("testMiss done");
  endtask
  task automatic testRecv();
    wr(IRQ_MASK_OFF, 8'h07);
    wr(CTRL1_OFF, 8'h02);
    m.start();
    ck(CTRL1_OFF, 8'h20, 8'h20);
    m.wrByte(8'hA8, nak);
    cmp({7'h0, nak}, 8'h00);
    ck(CTRL1_OFF, 8'hFF, 8'hE3);
    ci(1'b1);
    cmp(wakes[7:0], 8'h01);
    cmp({7'h0, sclOe}, 8'h01);
    rr(DATA_OFF);
    fork
      m.wrByte(8'h5A, nak);
      begin
        #800;
        ck(CTRL1_OFF, 8'h80, 8'h00);
      end
    join
    cmp({7'h0, nak}, 8'h00);
    ck(CTRL1_OFF, 8'h80, 8'h80);
    ck(DATA_OFF, 8'hFF, 8'h5A);
    wr(CTRL1_OFF, 8'h0A);
    m.wrByte(8'hC3, nak);
    cmp({7'h0, nak}, 8'h01);
    ck(DATA_OFF, 8'hFF, 8'hC3);
    m.stop();
    ck(CTRL1_OFF, 8'h20, 8'h00);
    ck(IRQ_STAT_OFF, 8'h07, 8'h07);
    wr(IRQ_MASK_OFF, 8'h00);
    ci(1'b0);
    wr(IRQ_MASK_OFF, 8'h07);
    ci(1'b1);
    wr(IRQ_STAT_OFF, 8'h07);
    ci(1'b0);
    $display("testRecv done");
  endtask
  task automatic testSend();
    wr(CTRL1_OFF, 8'h00);
    m.start();
    m.wrByte(8'hA9, nak);
    cmp({7'h0, nak}, 8'h00);
    ck(CTRL1_OFF, 8'h44, 8'h44);
    cmp(wakes[7:0], 8'h01);
    wr(CTRL1_OFF, 8'h10);
    wr(DATA_OFF, 8'h3C);
    m.rdByte(got, 1'b0);
    cmp(got, 8'h3C);
    ck(CTRL1_OFF, 8'h81, 8'h80);
    wr(DATA_OFF, 8'hC3);
    m.rdByte(got, 1'b1);
    cmp(got, 8'hC3);
    ck(CTRL1_OFF, 8'h01, 8'h01);
    cmp({7'h0, sdaW}, 8'h01);
    cmp({7'h0, sclOe}, 8'h00);
    m.stop();
    $display("testSend done");
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    testRegs();
    testMiss();
    testRecv();
    testSend();
    endSim();
  end
  // Seven bytes at 2 us plus register traffic; wide margin
  initial begin
    #200000;
    mismatches++;
    endSim();
  end
endmodule // iss_i2c_slave_test
`default_nettype wire
